// ### shared/sei_cfg.svh
// Constants of the serial EEPROM command interface: geometry, frame counts,
// opcodes and program timing. Assumes a 100 MHz system clock.
`ifndef SEI_CFG_SVH
`define SEI_CFG_SVH

`define SEI_AW           10
`define SEI_DW           16
`define SEI_DEPTH        1024
`define SEI_LAST_ADDR    10'h3FF
`define SEI_CW           6
`define SEI_SHW          28
`define SEI_CNT_MAX      6'h3F
`define SEI_CNT_ADDR     6'h0C
`define SEI_CNT_SHORT    6'h0D
`define SEI_CNT_LONG     6'h1D
`define SEI_OP_READ      2'h2
`define SEI_OP_WRITE     2'h1
`define SEI_OP_ERASE     2'h3
`define SEI_OP_EXT       2'h0
`define SEI_EX_FILL      2'h1
`define SEI_EX_CLEAR     2'h2
`define SEI_EX_UNLOCK    2'h3
`define SEI_EX_LOCK      2'h0
`define SEI_ERASED       16'hFFFF
`define SEI_CLK_MHZ      100
`define SEI_PROG_TYP_MS  2
`define SEI_PROG_MAX_MS  4
`define SEI_PROG_TYP_CYC (`SEI_PROG_TYP_MS * `SEI_CLK_MHZ * 1000)
`define SEI_PROG_MAX_CYC (`SEI_PROG_MAX_MS * `SEI_CLK_MHZ * 1000)
`define SEI_TMR_W        20
`define SEI_BCNT_W       21

`endif

// ### shared/sei_pkg.sv
// Types and command decoding of the serial EEPROM command interface.
// Assumes sei_cfg.svh is on the include path.
package sei_pkg;
`include "sei_cfg.svh"

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_SWEEP = 3'b010,
		ST_WAIT  = 3'b100
	} sei_state_e;

	typedef enum logic [2:0] {
		CMD_NONE, CMD_READ, CMD_WRITE, CMD_ERASE,
		CMD_FILL, CMD_CLEAR, CMD_UNLOCK, CMD_LOCK
	} sei_cmd_e;

	function automatic sei_cmd_e sei_decode(input logic [3:0] op);
		sei_cmd_e c;
		c = CMD_NONE;
		unique case (op[3:2])
			`SEI_OP_READ:  c = CMD_READ;
			`SEI_OP_WRITE: c = CMD_WRITE;
			`SEI_OP_ERASE: c = CMD_ERASE;
			`SEI_OP_EXT: begin
				unique case (op[1:0])
					`SEI_EX_FILL:   c = CMD_FILL;
					`SEI_EX_CLEAR:  c = CMD_CLEAR;
					`SEI_EX_UNLOCK: c = CMD_UNLOCK;
					`SEI_EX_LOCK:   c = CMD_LOCK;
				endcase
			end
		endcase
		return c;
	endfunction : sei_decode

	function automatic logic [`SEI_CW-1:0] sei_need(input sei_cmd_e c);
		return (c == CMD_WRITE || c == CMD_FILL) ? `SEI_CNT_LONG : `SEI_CNT_SHORT;
	endfunction : sei_need

	function automatic logic sei_is_write(input sei_cmd_e c);
		return c == CMD_WRITE || c == CMD_ERASE || c == CMD_FILL || c == CMD_CLEAR;
	endfunction : sei_is_write

endpackage : sei_pkg

// ### design/sei_sync.sv
// Two-flop level synchroniser with clock enable.
// Assumes each input bit is a level that stays put for several clocks.
`timescale 1ns/1ps
module sei_sync #(
	parameter int W = 1
) (
	// Clock
	input  wire logic         clk,
	input  wire logic         en,
	// Levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk) begin
		if (en) begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule : sei_sync

// ### design/sei_link.sv
// Link-side front end: start detection, bit count, shift register and read stream.
// Assumes serial_clock stands still while select is low and that the array
// word on rd_word only changes while no frame is being clocked.
`timescale 1ns/1ps
`include "sei_cfg.svh"
module sei_link
	import sei_pkg::*;
(
	// Link clock and frame
	input  wire logic                serial_clock,
	input  wire logic                select,
	input  wire logic                reset,
	input  wire logic                serial_in,
	// Array read
	input  wire logic [`SEI_DW-1:0]  rd_word,
	// Frame state
	output logic      [`SEI_CW-1:0]  cnt_q,
	output logic      [`SEI_SHW-1:0] sh_q,
	output logic      [`SEI_AW-1:0]  addr_q,
	output logic                     tog_q,
	output logic                     dout_q,
	output logic                     dout_en_q
);
	logic       fresh_q;
	logic       live_q;
	logic       rd_q;
	logic [3:0] bit_q;

	// A low select restarts the frame without a clock edge.
	wire logic clr = reset || !select;
	wire logic act = live_q && !fresh_q;
	wire logic start = !act && serial_in;
	wire logic take_addr = act && (cnt_q == `SEI_CNT_ADDR);
	wire logic is_read = sh_q[10:9] == `SEI_OP_READ;
	wire logic [`SEI_CW-1:0] cnt_inc = (cnt_q == `SEI_CNT_MAX) ? cnt_q : cnt_q + 6'h01;

	always_ff @(posedge serial_clock or posedge clr) begin
		if (clr) begin
			fresh_q   <= 1'b1;
			dout_en_q <= 1'b0;
		end else begin
			fresh_q <= 1'b0;
			if (take_addr && is_read)
				dout_en_q <= 1'b1;
		end
	end

	always_ff @(posedge serial_clock or posedge reset) begin
		if (reset) begin
			live_q <= 1'b0;
			cnt_q  <= '0;
			sh_q   <= '0;
			addr_q <= '0;
			tog_q  <= 1'b0;
			dout_q <= 1'b0;
			rd_q   <= 1'b0;
			bit_q  <= 4'h0;
		end else if (!act) begin
			live_q <= start;
			cnt_q  <= start ? 6'h01 : 6'h00;
			rd_q   <= 1'b0;
			bit_q  <= 4'h0;
			if (start)
				tog_q <= ~tog_q;
		end else begin
			cnt_q <= cnt_inc;
			sh_q  <= {sh_q[`SEI_SHW-2:0], serial_in};
			if (take_addr) begin
				addr_q <= {sh_q[8:0], serial_in};
				rd_q   <= is_read;
				dout_q <= 1'b0;
			end else if (rd_q) begin
				dout_q <= rd_word[4'hF - bit_q];
				bit_q  <= bit_q + 4'h1;
				if (bit_q == 4'hF)
					addr_q <= addr_q + 10'h001;
			end
		end
	end
endmodule : sei_link

// ### design/sei_top.sv
// Serial EEPROM command interface, 1024 x 16-bit array, device side.
// Assumes the link pins arrive unsynchronised; serial_clock is the link domain.
//
// Contract
// - First serial clock rise with serial_in high while selected is the start bit.
// - Clocks with serial_in low before the start bit are ignored.
// - Read drives low after address_bit_zero, then sixteen data bits, one per rise.
// - Further clocks after a read word stream the next address's word.
// - Sequential read address wraps from all ones to zero.
// - Write-type commands start programming when select falls after their clocks.
// - Clock and data are ignored while programming; host sends nothing then.
// - Write-type commands are dropped unless program_unlock mode is set.
// - Programming finishes within 4 ms, typically 2 ms.
// - Select high after a write shows low while busy, high when done.
// - Start bit while showing ready begins a command and floats serial_out.
// - Word write takes address and sixteen data bits, no erase first.
// - Extra clocks before select falls cancel a write-type command.
// - Word erase takes an address only and sets the word to all ones.
// - fill_all programs its data word into every location.
// - clear_all sets every bit of the array to one.
// - program_unlock and program_lock take effect when select falls.
// - Reset or low supply cancels writes and forces locked mode.
// - A low select ends command input and ignores clock and data.
// - Any clock count other than the required one cancels a write-type command.
`timescale 1ns/1ps
`include "sei_cfg.svh"
module sei_top
	import sei_pkg::*;
#(
	parameter int PROG_CYCLES = `SEI_PROG_TYP_CYC
) (
	// System
	input  wire logic sys_clk,
	input  wire logic reset,
	input  wire logic clk_en,
	// Serial link
	input  wire logic serial_clock,
	input  wire logic select,
	input  wire logic serial_in,
	output wire logic serial_out,
	output wire logic serial_out_oe_n,
	// Supply detector
	input  wire logic supply_low,
	// Status
	output wire logic prog_busy,
	output wire logic prog_unlocked
);
	// Link front end state.
	logic [`SEI_CW-1:0]  lk_cnt;
	logic [`SEI_SHW-1:0] lk_sh;
	logic [`SEI_AW-1:0]  lk_addr;
	logic                lk_tog;
	logic                lk_dout;
	logic                lk_den;
	logic [`SEI_DW-1:0]  rd_word;

	// Synchronised pins and link flags.
	logic                sel_s;
	logic                sup_s;
	logic                tog_s;
	logic                dout_s;
	logic                den_s;

	// System-side state.
	sei_state_e          st_q;
	sei_state_e          st_d;
	logic                sel_q;
	logic                seen_q;
	logic                busy_q;
	logic                unlock_q;
	logic                verify_q;
	logic                out_q;
	logic                oe_n_q;
	logic [`SEI_TMR_W-1:0] tmr_q;
	logic [`SEI_AW-1:0]  swp_q;
	logic [`SEI_DW-1:0]  fill_q;
	logic [`SEI_DW-1:0]  mem_q [`SEI_DEPTH];

	// The array holds its contents across reset, so it starts erased only once.
	initial begin
		for (int i = 0; i < `SEI_DEPTH; i++) begin
			mem_q[i] = `SEI_ERASED;
		end
	end

	sei_link u_link (
		.serial_clock (serial_clock),
		.select       (select),
		.reset        (reset),
		.serial_in    (serial_in),
		.rd_word      (rd_word),
		.cnt_q        (lk_cnt),
		.sh_q         (lk_sh),
		.addr_q       (lk_addr),
		.tog_q        (lk_tog),
		.dout_q       (lk_dout),
		.dout_en_q    (lk_den)
	);

	sei_sync #(.W(5)) u_sync (
		.clk (sys_clk),
		.en  (clk_en),
		.d   ({select, supply_low, lk_tog, lk_dout, lk_den}),
		.q   ({sel_s, sup_s, tog_s, dout_s, den_s})
	);

	// The link reads the array without a handshake. This is safe because the
	// array only changes while programming, and frames are ignored then, so
	// the word is settled long before any link edge samples it.
	assign rd_word = mem_q[lk_addr];

	// Frame capture at the falling select. The link counters and shift
	// register are stable here because no serial clock runs while deselected.
	wire logic fall    = sel_q && !sel_s;
	wire logic new_st  = tog_s != seen_q;
	wire logic go      = fall && new_st && !busy_q && !sup_s;
	wire logic long_f  = lk_cnt == `SEI_CNT_LONG;
	wire logic frm_ok  = long_f || lk_cnt == `SEI_CNT_SHORT;
	wire logic [3:0] op4 = long_f ? lk_sh[27:24] : lk_sh[11:8];

	sei_cmd_e cmd;
	assign cmd = frm_ok ? sei_decode(op4) : CMD_NONE;

	wire logic cnt_ok  = lk_cnt == sei_need(cmd);
	wire logic is_wr   = sei_is_write(cmd);
	wire logic go_wr   = go && is_wr && cnt_ok && unlock_q;
	wire logic go_all  = go_wr && (cmd == CMD_FILL || cmd == CMD_CLEAR);
	wire logic go_mode = go && cnt_ok && (cmd == CMD_UNLOCK || cmd == CMD_LOCK);
	wire logic keep_d  = cmd == CMD_WRITE || cmd == CMD_FILL;
	wire logic [`SEI_AW-1:0] f_addr = long_f ? lk_sh[25:16] : lk_sh[9:0];
	wire logic [`SEI_DW-1:0] f_data = keep_d ? lk_sh[15:0] : `SEI_ERASED;

	// Single array write port: one word at the fall, or one word per cycle in a sweep.
	wire logic in_sweep = st_q == ST_SWEEP;
	wire logic mem_we = (go_wr && !go_all) || in_sweep;
	wire logic [`SEI_AW-1:0] mem_wa = in_sweep ? swp_q : f_addr;
	wire logic [`SEI_DW-1:0] mem_wd = in_sweep ? fill_q : f_data;

	always_ff @(posedge sys_clk) begin
		if (clk_en && mem_we)
			mem_q[mem_wa] <= mem_wd;
	end

	// Programming sequencer.
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			ST_IDLE:  if (go_wr) st_d = go_all ? ST_SWEEP : ST_WAIT;
			ST_SWEEP: if (swp_q == `SEI_LAST_ADDR) st_d = ST_WAIT;
			ST_WAIT:  if (tmr_q == '0) st_d = ST_IDLE;
		endcase
		if (sup_s)
			st_d = ST_IDLE;
	end

	wire logic [`SEI_TMR_W-1:0] tmr_load = `SEI_TMR_W'(PROG_CYCLES - 1);
	wire logic [`SEI_TMR_W-1:0] tmr_d = go_wr ? tmr_load :
		(tmr_q == '0) ? tmr_q : tmr_q - `SEI_TMR_W'(1);

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			st_q   <= ST_IDLE;
			busy_q <= 1'b0;
			tmr_q  <= '0;
			swp_q  <= '0;
			fill_q <= `SEI_ERASED;
		end else if (clk_en) begin
			st_q   <= st_d;
			busy_q <= st_d != ST_IDLE;
			tmr_q  <= tmr_d;
			swp_q  <= in_sweep ? swp_q + 10'h001 : '0;
			if (go_all)
				fill_q <= f_data;
		end
	end

	// Mode, verify window and frame bookkeeping.
	wire logic unlock_d = sup_s ? 1'b0 : go_mode ? (cmd == CMD_UNLOCK) : unlock_q;
	wire logic restart = verify_q && sel_s && new_st && !busy_q;
	wire logic verify_d = go_wr ? 1'b1 : restart ? 1'b0 : verify_q;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sel_q    <= 1'b0;
			seen_q   <= 1'b0;
			unlock_q <= 1'b0;
			verify_q <= 1'b0;
		end else if (clk_en) begin
			sel_q    <= sel_s;
			seen_q   <= fall ? tog_s : seen_q;
			unlock_q <= unlock_d;
			verify_q <= verify_d;
		end
	end

	// Pin driver. Status shows while selected in the verify window and stays up while busy;
	// a start bit after ready hands the pin back to the host.
	wire logic show_st = verify_q && sel_s && (busy_q || !new_st);
	wire logic show_rd = den_s && sel_s && !busy_q;
	wire logic out_d   = show_st ? !busy_q : (show_rd && dout_s);
	wire logic oe_n_d  = !(show_st || show_rd);

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			out_q  <= 1'b0;
			oe_n_q <= 1'b1;
		end else if (clk_en) begin
			out_q  <= out_d;
			oe_n_q <= oe_n_d;
		end
	end

	assign serial_out      = out_q;
	assign serial_out_oe_n = oe_n_q;
	assign prog_busy       = busy_q;
	assign prog_unlocked   = unlock_q;

	// Checks. Frozen cycles are skipped by clocking on the enable.
	default clocking cb @(posedge sys_clk iff clk_en);
	endclocking
	default disable iff (reset);

	localparam int BUSY_MAX = PROG_CYCLES + `SEI_DEPTH + 2;
	logic [`SEI_BCNT_W-1:0] bcnt_q;

	always_ff @(posedge sys_clk) begin
		if (reset)
			bcnt_q <= '0;
		else if (clk_en)
			bcnt_q <= busy_q ? bcnt_q + `SEI_BCNT_W'(1) : '0;
	end

	prog_start_a: assert property (go_wr |=> busy_q && verify_q)
		else $error("accepted write did not start programming");

	lock_drop_a: assert property (go && is_wr && !unlock_q |=> !busy_q)
		else $error("write started while locked");

	count_cancel_a: assert property (
		fall && new_st && !busy_q && !frm_ok |=> !busy_q && $stable(unlock_q))
		else $error("frame of wrong length changed device state");

	count_exact_a: assert property ($rose(busy_q) |->
		$past(lk_cnt) == sei_need($past(cmd)) && $past(fall))
		else $error("programming started on a wrong clock count");

	busy_bound_a: assert property (bcnt_q <= `SEI_BCNT_W'(BUSY_MAX))
		else $error("programming ran past its time limit");

	verify_busy_a: assert property (
		verify_q && sel_s && busy_q |=> !oe_n_q && !out_q)
		else $error("busy not shown during verify");

	verify_ready_a: assert property (
		verify_q && sel_s && !busy_q && !new_st |=> !oe_n_q && out_q)
		else $error("ready not shown during verify");

	start_float_a: assert property (
		restart && !den_s |=> oe_n_q && !verify_q)
		else $error("pin not released on start bit after ready");

	busy_ignore_a: assert property (
		fall && busy_q |=> $stable(unlock_q) && $stable(verify_q))
		else $error("frame acted on while programming");

	erase_ones_a: assert property (
		go_wr && cmd == CMD_ERASE |-> mem_we && mem_wd == `SEI_ERASED && mem_wa == f_addr)
		else $error("erase did not write all ones");

	word_write_a: assert property (
		go_wr && cmd == CMD_WRITE |-> mem_we && mem_wa == lk_sh[25:16] && mem_wd == lk_sh[15:0])
		else $error("word write used wrong address or data");

	sweep_all_a: assert property (
		go_all |=> in_sweep && swp_q == '0 ##1 in_sweep && swp_q == 10'h001)
		else $error("array sweep did not start at address zero");

	sweep_data_a: assert property (in_sweep |-> mem_we && mem_wd == fill_q)
		else $error("sweep wrote a word other than the fill word");

	mode_fall_a: assert property ($changed(unlock_q) |-> $past(fall) || $past(sup_s))
		else $error("program mode changed without select falling");

	low_lock_a: assert property (sup_s |=> !unlock_q && !busy_q)
		else $error("low supply did not lock and cancel");

	write_cov: cover property (go_wr && cmd == CMD_WRITE ##[1:300] verify_q && sel_s);
	clear_cov: cover property (go_all && cmd == CMD_CLEAR);
	read_cov:  cover property ($rose(den_s) ##[1:100] !oe_n_q && out_q);
	ready_cov: cover property (restart);
endmodule : sei_top

// ### sim/sei_host.sv
// Host partner model: drives select, serial clock and data, and reads serial_out.
// Assumes a 32 ns serial clock that runs only inside frames.
`timescale 1ns/1ps
module sei_host (
	// Link outputs
	output logic      select,
	output logic      serial_clock,
	output logic      serial_in,
	// Device pin
	input  wire logic serial_out,
	input  wire logic serial_out_oe_n
);
	logic last;
	logic float_seen;

	initial begin
		select       = 1'b0;
		serial_clock = 1'b0;
		serial_in    = 1'b0;
		last         = 1'b0;
		float_seen   = 1'b1;
	end

	// The pin has no pull, so a floating line shows the inverse of its last level.
	task automatic tick(input logic d, output logic v);
		serial_in = d;
		#16;
		float_seen = serial_out_oe_n;
		v = serial_out_oe_n ? ~last : serial_out;
		last = v;
		serial_clock = 1'b1;
		#16 serial_clock = 1'b0;
	endtask : tick

	// Selects, sends idle clocks with serial_in low, then n bits MSB first.
	task automatic frame(input int pad, input logic [29:0] bits, input int n);
		logic v;
		select = 1'b1;
		#40;
		repeat (pad) tick(1'b0, v);
		for (int i = n - 1; i >= 0; i--) tick(bits[i], v);
	endtask : frame

	// Reads nw words; lead is the pin at the first rise after address_bit_zero.
	task automatic stream(input int nw, output logic [31:0] w, output logic [1:0] lead);
		logic v;
		w = 32'h0;
		#16;
		tick(1'b0, v);
		lead = {float_seen, v};
		for (int i = 0; i < 16 * nw; i++) begin
			tick(1'b0, v);
			w = {w[30:0], v};
		end
	endtask : stream

	// Ends the frame; the clock stays still while deselected.
	task automatic idle();
		select    = 1'b0;
		serial_in = 1'b0;
		#100;
	endtask : idle

	// Reselects with serial_in low and waits for ready at most lim ns.
	task automatic poll(input int lim, output logic [1:0] first, output int waited);
		serial_in = 1'b0;
		select    = 1'b1;
		#80;
		first  = {serial_out_oe_n, serial_out};
		waited = 0;
		while ((serial_out_oe_n !== 1'b0 || serial_out !== 1'b1) && waited < lim) begin
			#10;
			waited += 10;
		end
	endtask : poll
endmodule : sei_host

// ### sim/tb_sei_top.sv
// Self-checking bench of the serial EEPROM command interface.
// Assumes the package, design files and sim/sei_host.sv are compiled first.
`timescale 1ns/1ps
module tb_sei_top
	import sei_pkg::*;
;
	// Short program time keeps the run brief; the 4 ms bound scales to 2 * PC.
	localparam int PC = 2000;
	logic sys_clk, reset, clk_en, supply_low;
	wire  select, serial_clock, serial_in, serial_out, serial_out_oe_n;
	wire  prog_busy, prog_unlocked;
	int   mismatches;
	int   tests_run;

	sei_top #(.PROG_CYCLES(PC)) dut_u (
		.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
		.serial_clock(serial_clock), .select(select), .serial_in(serial_in),
		.serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
		.supply_low(supply_low), .prog_busy(prog_busy), .prog_unlocked(prog_unlocked)
	);

	sei_host host_u (
		.select(select), .serial_clock(serial_clock), .serial_in(serial_in),
		.serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n)
	);

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic results();
		$display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results

	function automatic logic [29:0] f13(input logic [1:0] op, input logic [9:0] a);
		return {17'h0, 1'b1, op, a};
	endfunction : f13

	function automatic logic [29:0] f29(input logic [1:0] op, input logic [9:0] a,
			input logic [15:0] d);
		return {1'b0, 1'b1, op, a, d};
	endfunction : f29

	task automatic cmd(input logic [29:0] bits, input int n);
		host_u.frame(0, bits, n);
		host_u.idle();
	endtask : cmd

	task automatic rd(input logic [9:0] a, input int nw, input logic [31:0] exp);
		logic [31:0] w;
		logic [1:0]  lead;
		host_u.frame(0, f13(2'h2, a), 13);
		host_u.stream(nw, w, lead);
		host_u.idle();
		chk(lead, 32'h0);
		chk(w, exp);
	endtask : rd

	task automatic wait_ready();
		logic [1:0] first;
		int         waited;
		host_u.poll(PC * 20, first, waited);
		chk(first, 32'h0);
		chk({serial_out_oe_n, serial_out}, 32'h1);
	endtask : wait_ready

	task automatic t_locked();
		chk({serial_out_oe_n, prog_busy, prog_unlocked}, 32'h4);
		cmd(f29(2'h1, 10'h005, 16'h1234), 29);
		chk(prog_busy, 32'h0);
		rd(10'h005, 1, 32'h0000FFFF);
		$display("locked test done");
	endtask : t_locked

	task automatic t_unlock();
		host_u.frame(3, f13(2'h0, 10'h300), 13);
		#60;
		chk(prog_unlocked, 32'h0);
		host_u.idle();
		chk(prog_unlocked, 32'h1);
		$display("unlock test done");
	endtask : t_unlock

	task automatic t_write();
		logic v;
		cmd(f29(2'h1, 10'h3FF, 16'h1234), 29);
		wait_ready();
		host_u.tick(1'b1, v);
		#80;
		chk(serial_out_oe_n, 32'h1);
		host_u.idle();
		rd(10'h3FF, 2, 32'h1234FFFF);
		$display("write test done");
	endtask : t_write

	task automatic t_count();
		logic [29:0] w;
		logic [29:0] e;
		w = f29(2'h1, 10'h000, 16'h0F0F);
		e = f13(2'h3, 10'h3FF);
		cmd(w >> 1, 28);
		chk(prog_busy, 32'h0);
		cmd(w << 1, 30);
		chk(prog_busy, 32'h0);
		cmd(e >> 1, 12);
		chk(prog_busy, 32'h0);
		cmd(e << 1, 14);
		chk(prog_busy, 32'h0);
		rd(10'h3FF, 2, 32'h1234FFFF);
		$display("count test done");
	endtask : t_count

	task automatic t_erase();
		cmd(f13(2'h3, 10'h3FF), 13);
		wait_ready();
		host_u.idle();
		rd(10'h3FF, 1, 32'h0000FFFF);
		$display("erase test done");
	endtask : t_erase

	task automatic t_fill();
		logic [1:0] first;
		int         waited;
		cmd(f29(2'h0, 10'h155, 16'hA5C3), 29);
		host_u.poll(0, first, waited);
		chk(first, 32'h0);
		host_u.idle();
		cmd(f13(2'h3, 10'h3FE), 13);
		wait_ready();
		host_u.idle();
		rd(10'h3FE, 2, 32'hA5C3A5C3);
		$display("fill test done");
	endtask : t_fill

	task automatic t_clear();
		cmd(f13(2'h0, 10'h200), 13);
		wait_ready();
		host_u.idle();
		rd(10'h001, 2, 32'hFFFFFFFF);
		$display("clear test done");
	endtask : t_clear

	task automatic t_lock();
		cmd(f13(2'h0, 10'h000), 13);
		chk(prog_unlocked, 32'h0);
		cmd(f13(2'h3, 10'h001), 13);
		chk(prog_busy, 32'h0);
		$display("lock test done");
	endtask : t_lock

	task automatic t_supply();
		cmd(f13(2'h0, 10'h300), 13);
		chk(prog_unlocked, 32'h1);
		// A detector pulse inside a frozen span never reaches the system side.
		@(posedge sys_clk);
		clk_en     <= 1'b0;
		supply_low <= 1'b1;
		repeat (5) @(posedge sys_clk);
		supply_low <= 1'b0;
		repeat (2) @(posedge sys_clk);
		clk_en <= 1'b1;
		repeat (5) @(posedge sys_clk);
		chk(prog_unlocked, 32'h1);
		@(posedge sys_clk);
		supply_low <= 1'b1;
		repeat (5) @(posedge sys_clk);
		supply_low <= 1'b0;
		repeat (5) @(posedge sys_clk);
		chk(prog_unlocked, 32'h0);
		cmd(f29(2'h1, 10'h000, 16'h5555), 29);
		chk(prog_busy, 32'h0);
		$display("supply test done");
	endtask : t_supply

	initial begin
		reset      = 1'b1;
		clk_en     = 1'b1;
		supply_low = 1'b0;
		mismatches = 0;
		tests_run  = 0;
		repeat (12) @(posedge sys_clk);
		reset <= 1'b0;
		repeat (4) @(posedge sys_clk);
		t_locked();
		t_unlock();
		t_write();
		t_count();
		t_erase();
		t_fill();
		t_clear();
		t_lock();
		t_supply();
		results();
	end

	// About 100 us of traffic is expected; five times that means a hang.
	initial begin
		#500000;
		mismatches++;
		$display("Watchdog expired at %0t", $time);
		results();
	end
endmodule : tb_sei_top
